// File: logic/tsm_sleep_ctrl.sv
// Sleep-mode controller: picks active, light sleep or deep sleep and gates
// the satellite receiver, the cellular modem and record saving.
// Wake inputs come from pins and pass a three-stage synchroniser.
`timescale 1ns/1ps
module tsm_sleep_ctrl
  import tsm_pkg::*;
#(
  parameter longint unsigned STARTUP_COUNT = STARTUP_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic lightSelect,
  input wire logic deepSelect,
  input wire logic [SEND_PERIOD_W-1:0] sendPeriodSec,
  input wire logic accelMove,
  input wire logic ignition_input,
  input wire logic usbPresent,
  input wire tsm_rec_s recReq,
  input wire logic txRequest,
  output logic gnssSleep,
  output logic modemPower,
  output logic txGrant,
  output tsm_save_s recSave,
  output logic lightActive,
  output logic deepActive,
  output logic startupDone
);

  // Three-stage synchronisers for the wake pins, plus the settled level of each.
  // Stage zero may be metastable and is read only by stage one.
  logic [2:0] moveSync_q, moveSync_d;
  logic [2:0] ignSync_q, ignSync_d;
  logic [2:0] usbSync_q, usbSync_d;
  logic moveLvl_q, moveLvl_d;
  logic ignLvl_q, ignLvl_d;
  logic usbLvl_q, usbLvl_d;

  // A level changes only once the second and third stages agree.
  // While they differ the previous settled level is kept.
  function automatic logic settle(input logic [2:0] s, input logic cur);
    return (s[1] == s[2]) ? s[2] : cur;
  endfunction

  // High and panic records both demand immediate attention.
  function automatic logic isUrgent(input tsm_prio_e p);
    return p != PRIO_LOW;
  endfunction

  always_comb begin
    moveSync_d = {moveSync_q[1:0], accelMove};
    ignSync_d = {ignSync_q[1:0], ignition_input};
    usbSync_d = {usbSync_q[1:0], usbPresent};
    moveLvl_d = settle(moveSync_q, moveLvl_q);
    ignLvl_d = settle(ignSync_q, ignLvl_q);
    usbLvl_d = settle(usbSync_q, usbLvl_q);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      moveSync_q <= 3'h0;
      ignSync_q <= 3'h0;
      usbSync_q <= 3'h0;
      moveLvl_q <= 1'b0;
      ignLvl_q <= 1'b0;
      usbLvl_q <= 1'b0;
    end else begin
      moveSync_q <= moveSync_d;
      ignSync_q <= ignSync_d;
      usbSync_q <= usbSync_d;
      moveLvl_q <= moveLvl_d;
      ignLvl_q <= ignLvl_d;
      usbLvl_q <= usbLvl_d;
    end
  end

  tsm_state_e state_q, state_d;
  // The start-up count covers five minutes of system clock, which needs more than 32 bits.
  // Counting stops once the count is reached so the timer never wraps.
  logic [63:0] timer_q, timer_d;
  logic gnssSleep_q, gnssSleep_d;
  logic modemPower_q, modemPower_d;
  logic txGrant_q, txGrant_d;
  tsm_save_s recSave_q, recSave_d;
  logic startupDone_q, startupDone_d;

  // Combinational decisions used by the next-state logic.
  logic urgentRec;
  logic wake;
  logic quiet;
  logic deepOk;

  always_comb begin
    // A deep sleep element record never counts as an urgent wake source.
    urgentRec = recReq.valid && !recReq.deepSleepElem
      && isUrgent(recReq.prio);
    wake = moveLvl_q || ignLvl_q || usbLvl_q || urgentRec;
    // Quiet means no wake pin is active and the start-up timer has run out.
    // Urgent records are kept out of quiet separately so that a record arriving on the
    // decision cycle keeps the unit awake.
    quiet = startupDone_q && !moveLvl_q && !ignLvl_q && !usbLvl_q;
    deepOk = deepSelect && (sendPeriodSec > SEND_PERIOD_W'(DEEP_MIN_SEND_SEC));
  end

  // Only the active state decides which sleep state to enter. Deep sleep is preferred
  // when both are selected and allowed, as it saves the most power.
  // A sleeping state is left only through a wake source; a change of configuration while
  // asleep takes effect after the next wake.
  always_comb begin
    state_d = state_q;
    timer_d = timer_q;
    startupDone_d = startupDone_q;
    unique case (state_q)
      ST_STARTUP: begin
        // Count cycles until the start-up time has passed; both sleep states wait for this.
        if (timer_q >= STARTUP_COUNT - 64'd1) begin
          startupDone_d = 1'b1;
          state_d = ST_ACTIVE;
        end else begin
          timer_d = timer_q + 64'd1;
        end
      end
      ST_ACTIVE: begin
        // Urgent records block entry on the cycle they arrive.
        if (quiet && !urgentRec && deepOk) begin
          state_d = ST_DEEP;
        end else if (quiet && !urgentRec && lightSelect) begin
          state_d = ST_LIGHT;
        end
      end
      ST_LIGHT: begin
        // Any one wake source is enough.
        if (wake) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_DEEP: begin
        // Any one wake source is enough, but the modem is off so text messages cannot wake.
        if (wake) begin
          state_d = ST_ACTIVE;
        end
      end
    endcase
  end

  // Gating outputs follow the next state so that they change on the same edge as the
  // mode flags. The modem follows the transmit request in deep sleep, one cycle late.
  // Record saving uses the present state: a record on the cycle that ends light sleep
  // is dropped, as the unit was still asleep when it arrived.
  always_comb begin
    gnssSleep_d = (state_d == ST_LIGHT) || (state_d == ST_DEEP);
    modemPower_d = 1'b1;
    // Transmission is held off in light sleep; in deep sleep it powers the modem.
    txGrant_d = txRequest && (state_d != ST_LIGHT);
    if (state_d == ST_DEEP) begin
      modemPower_d = txRequest;
    end
    recSave_d = SAVE_IDLE;
    if (recReq.valid && state_q != ST_LIGHT) begin
      recSave_d.save = 1'b1;
      recSave_d.elems = ELEM_ALL;
      // The deep sleep element stays low priority whatever the request says.
      if (!recReq.deepSleepElem) begin
        recSave_d.sendNow = isUrgent(recReq.prio);
        recSave_d.textCopy = (recReq.prio == PRIO_PANIC);
      end
      // Deep sleep records keep the last valid fix and only the reduced element set.
      if (state_q == ST_DEEP) begin
        recSave_d.useLastFix = 1'b1;
        recSave_d.elems = ELEM_DEEP;
      end
    end
  end

  // Reset puts the unit back in start-up with the receiver and modem powered, so a
  // restart always runs the full start-up time before any sleep.
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= ST_STARTUP;
      timer_q <= 64'h0;
      startupDone_q <= 1'b0;
      gnssSleep_q <= 1'b0;
      modemPower_q <= 1'b1;
      txGrant_q <= 1'b0;
      recSave_q <= SAVE_IDLE;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      startupDone_q <= startupDone_d;
      gnssSleep_q <= gnssSleep_d;
      modemPower_q <= modemPower_d;
      txGrant_q <= txGrant_d;
      recSave_q <= recSave_d;
    end
  end

  logic lightActive_q, lightActive_d;
  logic deepActive_q, deepActive_d;

  // The mode flags report the state being entered, in step with the gating outputs.
  always_comb begin
    lightActive_d = (state_d == ST_LIGHT);
    deepActive_d = (state_d == ST_DEEP);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      lightActive_q <= 1'b0;
      deepActive_q <= 1'b0;
    end else begin
      lightActive_q <= lightActive_d;
      deepActive_q <= deepActive_d;
    end
  end

  // Every output is taken straight from a register.
  assign gnssSleep = gnssSleep_q;
  assign modemPower = modemPower_q;
  assign txGrant = txGrant_q;
  assign recSave = recSave_q;
  assign lightActive = lightActive_q;
  assign deepActive = deepActive_q;
  assign startupDone = startupDone_q;

endmodule // tsm_sleep_ctrl

// File: logic/tsm_pkg.sv
// Constants, state types and carriers for the tracker sleep-mode controller.
// Assumes a single 200 MHz system clock with a synchronous active-high reset.
// Notes on behaviour
// - Light sleep needs selection, expired start-up timer, no movement, ignition off, no USB.
// - Five-minute start-up timer runs after every restart and blocks both sleep states.
// - Light sleep puts the satellite receiver to sleep and keeps the modem active.
// - Any wake source ends light sleep: movement, ignition, USB, high or panic record.
// - Light sleep suppresses periodic and event record saving.
// - Deep sleep puts the receiver to sleep and powers the modem down.
// - In deep sleep the modem is powered only while a server transmission runs.
// - Deep sleep needs deep selection, other light conditions, and send period above 60 s.
// - Any wake source ends deep sleep: movement, ignition, USB, high or panic record.
// - Deep sleep still saves records, stamped with the last valid fix.
// - Deep sleep records carry only the reduced element set.
// - The deep sleep element is always low priority and never wakes or sends.
// - Low records queue, high send at once, panic send and duplicate as text.
package tsm_pkg;

  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned STARTUP_SEC = 300;
  localparam longint unsigned STARTUP_CYCLES = longint'(STARTUP_SEC) * CLK_HZ;
  localparam int unsigned DEEP_MIN_SEND_SEC = 60;
  localparam int unsigned SEND_PERIOD_W = 32;

  typedef enum logic [1:0] {
    PRIO_LOW,
    PRIO_HIGH,
    PRIO_PANIC
  } tsm_prio_e;

  typedef enum {
    ST_STARTUP,
    ST_ACTIVE,
    ST_LIGHT,
    ST_DEEP
  } tsm_state_e;

  // Element groups a record may carry; reduced set is used in deep sleep.
  typedef struct packed {
    logic digIn;
    logic anaIn;
    logic battVolt;
    logic battCurr;
    logic digOut;
    logic extVolt;
    logic movement;
    logic deepSleep;
    logic position;
    logic otherIo;
  } tsm_elem_s;

  localparam tsm_elem_s ELEM_ALL = 10'h3ff;
  localparam tsm_elem_s ELEM_DEEP = 10'h3fc;

  // Record request from the acquisition logic.
  typedef struct packed {
    logic valid;
    logic periodic;
    logic deepSleepElem;
    tsm_prio_e prio;
  } tsm_rec_s;

  // Record save command towards storage and transmit logic.
  typedef struct packed {
    logic save;
    logic sendNow;
    logic textCopy;
    logic useLastFix;
    tsm_elem_s elems;
  } tsm_save_s;

  localparam tsm_save_s SAVE_IDLE = '0;

endpackage

// File: verif/tsm_sleep_sva.sv
// Port checker for the sleep-mode controller.
// Bound to every controller instance; one clock domain.
`timescale 1ns/1ps
module tsm_sleep_sva
  import tsm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic txRequest,
  input wire tsm_rec_s recReq,
  input wire logic gnssSleep,
  input wire logic modemPower,
  input wire tsm_save_s recSave,
  input wire logic lightActive,
  input wire logic deepActive,
  input wire logic startupDone
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_sleep_after_start: assert property ((lightActive || deepActive) |-> startupDone)
    else $error("sleep before start-up");
  chk_light_gnss_modem: assert property (lightActive |-> gnssSleep && modemPower)
    else $error("light gating wrong");
  chk_light_no_save: assert property ($past(lightActive) |-> !recSave.save)
    else $error("save in light sleep");
  chk_deep_gnss: assert property (deepActive |-> gnssSleep)
    else $error("receiver awake in deep");
  chk_deep_modem_tx: assert property (deepActive && $past(deepActive)
    |-> modemPower == $past(txRequest))
    else $error("modem not following transmit");
  chk_deep_elems: assert property (recSave.save && $past(deepActive)
    |-> recSave.elems == ELEM_DEEP && recSave.useLastFix)
    else $error("deep record contents");
  chk_elem_low: assert property (recReq.valid && recReq.deepSleepElem
    |=> !recSave.sendNow && !recSave.textCopy)
    else $error("sleep element not low");
  chk_light_wake: assert property (lightActive && recReq.valid && !recReq.deepSleepElem
    && recReq.prio != PRIO_LOW |=> !lightActive)
    else $error("no wake from record");
  cover property (lightActive);
  cover property (deepActive && modemPower);
  cover property (recSave.textCopy);
endmodule // tsm_sleep_sva

bind tsm_sleep_ctrl tsm_sleep_sva u_sva (.mclk, .rst, .txRequest, .recReq, .gnssSleep,
  .modemPower, .recSave, .lightActive, .deepActive, .startupDone);

// File: verif/tsm_modem_model.sv
// Modem model: raises its transmit request for four cycles per go pulse.
// Assumes the controller clock.
`timescale 1ns/1ps
module tsm_modem_model (
  input wire logic mclk,
  input wire logic go,
  output logic txRequest
);
  logic [2:0] left = '0;
  always @(posedge mclk) left <= go ? 3'h4 : (left != 0 ? left - 1 : left);
  assign txRequest = left != 0;
endmodule // tsm_modem_model

// File: verif/tb_top.sv
// Directed bench for the sleep-mode controller.
// Assumes a shortened start-up count of 20 cycles.
`timescale 1ns/1ps
module tb_top;
  import tsm_pkg::*;
  logic mclk = 0, rst = 1, lightSelect = 1, deepSelect = 0, accelMove = 0;
  logic ignition_input = 0, usbPresent = 0, go = 0;
  logic txRequest, gnssSleep, modemPower, txGrant, lightActive, deepActive, startupDone;
  logic [SEND_PERIOD_W-1:0] sendPeriodSec = 32'h3c;
  tsm_rec_s recReq = '0;
  tsm_save_s recSave;
  int failures = 0, nChecks = 0, cyc = 0;
  always #2.5 mclk = ~mclk;
  tsm_sleep_ctrl #(.STARTUP_COUNT(20)) dut (.mclk, .rst, .lightSelect, .deepSelect,
    .sendPeriodSec, .accelMove, .ignition_input, .usbPresent, .recReq, .txRequest,
    .gnssSleep, .modemPower, .txGrant, .recSave, .lightActive, .deepActive, .startupDone);
  tsm_modem_model partner (.mclk, .go, .txRequest);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    nChecks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    if (failures == 0 && nChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic rec(input tsm_prio_e p, input logic elem);
    @(posedge mclk) recReq <= '{1'b1, 1'b0, elem, p};
    @(posedge mclk) recReq <= '0;
    #1;
  endtask
  task t_light;
    wt(10);
    chk({startupDone, lightActive}, 2'h0);
    wt(30);
    chk({startupDone, lightActive, gnssSleep, modemPower}, 4'hf);
    rec(PRIO_LOW, 0);
    chk(recSave.save, 0);
    rec(PRIO_HIGH, 0);
    chk({lightActive, gnssSleep}, 0);
  endtask
  task t_deep;
    @(posedge mclk) deepSelect <= 1;
    rec(PRIO_HIGH, 0);
    wt(2);
    chk(deepActive, 0);
    @(posedge mclk) sendPeriodSec <= 32'h3d;
    rec(PRIO_HIGH, 0);
    wt(2);
    chk({deepActive, gnssSleep, modemPower}, 3'h6);
    @(posedge mclk) go <= 1;
    @(posedge mclk) go <= 0;
    wt(2);
    chk({modemPower, txGrant}, 2'h3);
    wt(6);
    chk(modemPower, 0);
    rec(PRIO_LOW, 0);
    chk({recSave.save, recSave.useLastFix, recSave.elems}, {2'h3, ELEM_DEEP});
    rec(PRIO_HIGH, 1);
    chk({deepActive, recSave.sendNow}, 2'h2);
    @(posedge mclk) ignition_input <= 1;
    wt(8);
    chk({deepActive, gnssSleep, modemPower}, 3'h1);
    rec(PRIO_PANIC, 0);
    chk({recSave.save, recSave.sendNow, recSave.textCopy}, 3'h7);
  endtask
  task t_restart;
    @(posedge mclk) begin
      rst <= 1;
      ignition_input <= 0;
    end
    wt(2);
    @(posedge mclk) rst <= 0;
    wt(1);
    chk({startupDone, gnssSleep, modemPower, txGrant, lightActive, deepActive}, 6'h08);
    wt(12);
    chk({startupDone, lightActive, deepActive}, 3'h0);
    wt(15);
    chk({startupDone, lightActive, deepActive}, 3'h5);
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      stop_test;
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 0;
    t_light;
    t_deep;
    t_restart;
    stop_test;
  end
endmodule // tb_top
